/* File: rtl/peripheral_input_pin_select.sv */
// Purpose: Input remapping of UART1 CTS, UART1 RX and PWM fault four
// Assumes: APB master on clk_sys; remappable pins are asynchronous
// Notes: Pin to peripheral input latency is three clk_sys edges
`timescale 1ns/1ps
module peripheral_input_pin_select
   import pin_select_pkg::*;
#(
   parameter int PIN_COUNT = NUM_PINS
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PIN_COUNT-1:1] remappablePin,
   output logic uart1ClearToSendInput,
   output logic uart1ReceiveInput,
   output logic pwmFaultFourInput
);
   if (PIN_COUNT < 2 || PIN_COUNT > (1 << CODE_W)) begin : g_bad_count
      $error("peripheral_input_pin_select: PIN_COUNT out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [REG_W-1:0] uart1Sel_reg;
   logic [REG_W-1:0] uart1Sel_next;
   logic [CODE_W-1:0] fault4Code_reg;
   logic [CODE_W-1:0] fault4Code_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [PIN_COUNT-1:1] pinMeta_reg;
   logic [PIN_COUNT-1:1] pinSync_reg;
   logic [PIN_COUNT-1:0] pinLevels;
   logic mapped;
   logic setupPhase;
   logic wrAccess;
   pin_sel_if #(.N_CH(NUM_CH), .CODE_W(CODE_W)) selBus ();

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states, error on unmapped address
   assign mapped = (paddr == ADDR_UART1_SEL) || (paddr == ADDR_FAULT_SEL);
   assign setupPhase = psel && !penable;
   assign wrAccess = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_reg;

   // Next register values from writes
   always_comb begin
      uart1Sel_next = uart1Sel_reg;
      fault4Code_next = fault4Code_reg;
      if (wrAccess && paddr == ADDR_UART1_SEL) begin
         uart1Sel_next = pwdata[REG_W-1:0];
      end
      if (wrAccess && paddr == ADDR_FAULT_SEL) begin
         fault4Code_next = pwdata[FAULT4_LSB +: CODE_W];
      end
   end

   // Read data captured in the setup phase, upper bits read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (setupPhase && !pwrite) begin
         rdata_next = DATA_ZERO;
         if (paddr == ADDR_UART1_SEL) begin
            rdata_next[REG_W-1:0] = uart1Sel_reg;
         end else if (paddr == ADDR_FAULT_SEL) begin
            rdata_next[FAULT4_LSB +: CODE_W] = fault4Code_reg;
         end
      end
   end

   // Register state, all selectors cleared at reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         uart1Sel_reg <= REG_RESET;
         fault4Code_reg <= CODE_GROUND;
         rdata_reg <= DATA_ZERO;
      end else begin
         uart1Sel_reg <= uart1Sel_next;
         fault4Code_reg <= fault4Code_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser on every remappable pin
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
      end else begin
         pinMeta_reg <= remappablePin;
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Index zero is the ground level
   assign pinLevels = {pinSync_reg, 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // Selector codes to the mux
   assign selBus.code[CH_CTS] = uart1Sel_reg[CTS_LSB +: CODE_W];
   assign selBus.code[CH_RX] = uart1Sel_reg[RX_LSB +: CODE_W];
   assign selBus.code[CH_PWM_FAULT_FOUR_INPUT] = fault4Code_reg;

   // Code n drives the input from pin n
   pin_select_mux #(
      .N_CH(NUM_CH),
      .PINS(PIN_COUNT),
      .CODE_W(CODE_W)
   ) u_mux (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pins(pinLevels),
      .sel(selBus.mux)
   );

   assign uart1ClearToSendInput = selBus.selBit[CH_CTS];
   assign uart1ReceiveInput = selBus.selBit[CH_RX];
   assign pwmFaultFourInput = selBus.selBit[CH_PWM_FAULT_FOUR_INPUT];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [CODE_W-1:0] ctsCode;
   logic [CODE_W-1:0] rxCode;
   assign ctsCode = uart1Sel_reg[CTS_LSB +: CODE_W];
   assign rxCode = uart1Sel_reg[RX_LSB +: CODE_W];

   sequence s_uart_write;
      psel && penable && pwrite && paddr == ADDR_UART1_SEL;
   endsequence
   sequence s_uart_read;
      psel && !penable && !pwrite && paddr == ADDR_UART1_SEL ##1 psel && penable;
   endsequence

   property p_cts_pin;
      @(posedge clk_sys) disable iff (!nrst)
      (ctsCode != CODE_GROUND && int'(ctsCode) < PIN_COUNT)
         |=> uart1ClearToSendInput == $past(pinLevels[ctsCode]);
   endproperty
   a_cts_pin: assert property (p_cts_pin) else $error("cts input does not follow chosen pin");

   property p_rx_pin;
      @(posedge clk_sys) disable iff (!nrst)
      $stable(rxCode) && int'(rxCode) < PIN_COUNT ##1 $stable(rxCode)
         |=> uart1ReceiveInput == $past(pinLevels[rxCode]);
   endproperty
   a_rx_pin: assert property (p_rx_pin) else $error("rx input does not follow chosen pin");

   property p_fault_pin;
      @(posedge clk_sys) disable iff (!nrst)
      (fault4Code_reg != CODE_GROUND && int'(fault4Code_reg) < PIN_COUNT)
         |=> pwmFaultFourInput == $past(pinLevels[fault4Code_reg]);
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault four input does not follow chosen pin");

   property p_ground;
      @(posedge clk_sys) disable iff (!nrst)
      (ctsCode == CODE_GROUND) [*2] |-> !uart1ClearToSendInput;
   endproperty
   a_ground: assert property (p_ground) else $error("ground code does not give low level");

   property p_rx_ground;
      @(posedge clk_sys) disable iff (!nrst)
      (rxCode == CODE_GROUND) [*2] |-> !uart1ReceiveInput;
   endproperty
   a_rx_ground: assert property (p_rx_ground) else $error("ground code does not give low receive level");

   property p_fault_ground;
      @(posedge clk_sys) disable iff (!nrst)
      (fault4Code_reg == CODE_GROUND) [*2] |-> !pwmFaultFourInput;
   endproperty
   a_fault_ground: assert property (p_fault_ground) else $error("ground code does not give low fault level");

   property p_rp181;
      @(posedge clk_sys) disable iff (!nrst)
      (rxCode == CODE_RP181) [*4] |-> uart1ReceiveInput == $past(remappablePin[CODE_RP181], 3);
   endproperty
   a_rp181: assert property (p_rp181) else $error("code B5 does not select pin 181");

   property p_rp180;
      @(posedge clk_sys) disable iff (!nrst)
      (fault4Code_reg == CODE_RP180) [*4] |-> pwmFaultFourInput == $past(remappablePin[CODE_RP180], 3);
   endproperty
   a_rp180: assert property (p_rp180) else $error("code B4 does not select pin 180");

   property p_rp1;
      @(posedge clk_sys) disable iff (!nrst)
      (ctsCode == CODE_RP1) [*4] |-> uart1ClearToSendInput == $past(remappablePin[CODE_RP1], 3);
   endproperty
   a_rp1: assert property (p_rp1) else $error("code 01 does not select pin 1");

   // Write, one idle cycle, then a read of the same register
   property p_readback;
      @(posedge clk_sys) disable iff (!nrst)
      s_uart_write ##2 s_uart_read |-> prdata[REG_W-1:0] == $past(pwdata[REG_W-1:0], 3);
   endproperty
   a_readback: assert property (p_readback) else $error("uart1 select read back differs");

   property p_upper_zero;
      @(posedge clk_sys) disable iff (!nrst)
      psel && penable && !pwrite |-> prdata[31:REG_W] == '0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("unused read data bits not zero");

   property p_reset_clear;
      @(posedge clk_sys) $rose(nrst) |-> uart1Sel_reg == REG_RESET && fault4Code_reg == CODE_GROUND;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("selectors not cleared by reset");
endmodule // peripheral_input_pin_select

/* File: rtl/pin_select_pkg.sv */
// Purpose: Shared constants for the peripheral input pin select block
// Assumes: 32-bit APB register bus, one aligned word per register
// Notes: Selector code n picks remappable pin n, code zero picks ground
package pin_select_pkg;
   // Register byte addresses
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_UART1_SEL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_SEL = 12'h004;
   // Field layout
   localparam int CODE_W = 8;
   localparam int CTS_LSB = 8;
   localparam int RX_LSB = 0;
   localparam int FAULT4_LSB = 8;
   localparam int REG_W = 16;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   // Selector codes of note
   localparam logic [CODE_W-1:0] CODE_GROUND = 8'h00;
   localparam logic [CODE_W-1:0] CODE_RP1 = 8'h01;
   localparam logic [CODE_W-1:0] CODE_RP180 = 8'hB4;
   localparam logic [CODE_W-1:0] CODE_RP181 = 8'hB5;
   // Pin count: code values 0..181, index 0 is the ground level
   localparam int NUM_PINS = 182;
   // Channels
   localparam int NUM_CH = 3;
   localparam int CH_CTS = 0;
   localparam int CH_RX = 1;
   localparam int CH_PWM_FAULT_FOUR_INPUT = 2;
endpackage

/* File: rtl/pin_sel_if.sv */
// Purpose: Carries selector codes to the mux and selected levels back
// Assumes: One code and one selected level per channel
// Notes: ctrl side owns the codes, mux side owns the selected levels
`timescale 1ns/1ps
interface pin_sel_if #(
   parameter int N_CH = 3,
   parameter int CODE_W = 8
);
   logic [CODE_W-1:0] code [N_CH];
   logic selBit [N_CH];
   modport ctrl (output code, input selBit);
   modport mux (input code, output selBit);
endinterface // pin_sel_if

/* File: rtl/pin_select_mux.sv */
// Purpose: Registered multiplexer from synchronised pins to peripheral inputs
// Assumes: pins[0] is tied low by the caller and stands for ground
// Notes: Codes above the highest pin read as low
`timescale 1ns/1ps
module pin_select_mux #(
   parameter int N_CH = 3,
   parameter int PINS = 182,
   parameter int CODE_W = 8
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [PINS-1:0] pins,
   pin_sel_if.mux sel
);
   if (PINS > (1 << CODE_W)) begin : g_bad_width
      $error("pin_select_mux: PINS exceeds what CODE_W can address");
   end

   ////////////////////////////////////////////////////////////////////////////
   // One registered selector per channel
   for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
      logic out_reg;
      logic out_next;
      // Pick the addressed pin, ground for code zero or out of range
      always_comb begin
         if (int'(sel.code[ch]) < PINS) begin
            out_next = pins[sel.code[ch]];
         end else begin
            out_next = 1'b0;
         end
      end
      // Register the selection
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            out_reg <= 1'b0;
         end else begin
            out_reg <= out_next;
         end
      end
      assign sel.selBit[ch] = out_reg;
   end
endmodule // pin_select_mux

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the peripheral input pin select block
// Assumes: Zero wait state APB slave, three edge pin to output latency
// Notes: Walks selector codes over all three channels with one-hot pin patterns
`timescale 1ns/1ps
module testbench;
   import pin_select_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = DATA_ZERO;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NUM_PINS-1:1] remappablePin = '1;
   logic uart1ClearToSendInput;
   logic uart1ReceiveInput;
   logic pwmFaultFourInput;
   int failCount = 0;
   int checked = 0;
   logic [31:0] rd;
   logic err;
   logic [NUM_PINS-1:0] pat;
   logic [CODE_W-1:0] codes [7] = '{8'h00, 8'h01, 8'h5A, 8'hB4, 8'hB5, 8'hB6, 8'hFF};
   logic [CODE_W-1:0] cc, rc, fc;

   peripheral_input_pin_select peripheral_input_pin_select_inst (
      .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .remappablePin(remappablePin), .uart1ClearToSendInput(uart1ClearToSendInput),
      .uart1ReceiveInput(uart1ReceiveInput), .pwmFaultFourInput(pwmFaultFourInput));

   // 50 MHz system clock
   always #10 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////////
   // Report and compare tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer, entered just after a rising edge, leaves one idle edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failCount++;
         $display("mismatch at %0t: no ready", $time);
         close_out();
      end else begin
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys);
      end
   endtask

   // Expected level of a channel for a code and a pin pattern
   function automatic logic lvl(input logic [CODE_W-1:0] c, input logic [NUM_PINS-1:0] p);
      if (c >= CODE_RP1 && c <= CODE_RP181) return p[c];
      return 1'b0;
   endfunction

   // Drive a pattern, let four edges pass, check all three outputs
   task automatic pins_check(input logic [NUM_PINS-1:0] p);
      remappablePin <= p[NUM_PINS-1:1];
      repeat (4) @(posedge clk_sys);
      cmp1(uart1ClearToSendInput, lvl(cc, p));
      cmp1(uart1ReceiveInput, lvl(rc, p));
      cmp1(pwmFaultFourInput, lvl(fc, p));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      cc = CODE_GROUND;
      rc = CODE_GROUND;
      fc = CODE_GROUND;
      // All pins high, yet every output sits at ground after reset
      pins_check('1);
      apb(1'b0, ADDR_UART1_SEL, DATA_ZERO, rd, err);
      cmp32(rd, {16'h0000, REG_RESET});
      apb(1'b0, ADDR_FAULT_SEL, DATA_ZERO, rd, err);
      cmp32(rd, {16'h0000, REG_RESET});
      // Walk codes, each channel offset in the table
      for (int i = 0; i < 7; i++) begin
         cc = codes[i];
         rc = codes[(i + 1) % 7];
         fc = codes[(i + 2) % 7];
         apb(1'b1, ADDR_UART1_SEL, {16'hFFFF, cc, rc}, rd, err);
         apb(1'b0, ADDR_UART1_SEL, DATA_ZERO, rd, err);
         cmp32(rd, {16'h0000, cc, rc});
         apb(1'b1, ADDR_FAULT_SEL, {16'hA5A5, fc, 8'hFF}, rd, err);
         apb(1'b0, ADDR_FAULT_SEL, DATA_ZERO, rd, err);
         cmp32(rd, {16'h0000, fc, 8'h00});
         pat = {{(NUM_PINS - 1){1'b0}}, 1'b1} << cc;
         pins_check(pat);
         pins_check(~pat);
         pins_check({{(NUM_PINS - 1){1'b0}}, 1'b1} << rc);
         pins_check({{(NUM_PINS - 1){1'b0}}, 1'b1} << fc);
      end
      // Unmapped address flags an error, reads zero, disturbs nothing
      apb(1'b1, 12'h008, 32'hFFFF_FFFF, rd, err);
      cmp1(err, 1'b1);
      apb(1'b0, 12'h008, DATA_ZERO, rd, err);
      cmp32(rd, DATA_ZERO);
      apb(1'b0, ADDR_UART1_SEL, DATA_ZERO, rd, err);
      cmp1(err, 1'b0);
      cmp32(rd, {16'h0000, cc, rc});
      // Reset in mid-run clears every selector back to ground
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      cc = CODE_GROUND;
      rc = CODE_GROUND;
      fc = CODE_GROUND;
      apb(1'b0, ADDR_UART1_SEL, DATA_ZERO, rd, err);
      cmp32(rd, DATA_ZERO);
      apb(1'b0, ADDR_FAULT_SEL, DATA_ZERO, rd, err);
      cmp32(rd, DATA_ZERO);
      pins_check('1);
      close_out();
   end
endmodule // testbench
